// ===== rtl/ldw_counter.sv
/*
 * watchdog counter core: counts qualified ticks, flags overflow.
 * assumes clear and tick qualification come from the register front.
 */
`timescale 1ns/1ps
`include "ldw_params.svh"
module ldw_counter (
    input wire logic clk_sys,
    input wire logic resetn,
    ldw_cnt_if.core cnt
);
    import ldw_pkg::*;

    logic [`LDW_CNT_WIDTH-1:0] count;

    // clear wins over counting so a service never loses to a tick
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            count <= '0;
        end else if (cnt.clear) begin
            count <= '0;
        end else if (cnt.count_en) begin
            count <= count + `LDW_CNT_WIDTH'(1);
        end
    end

    // overflow when the count hits 2^exp; width covers 2^20
    assign cnt.overflow = count[cnt.limit_exp];
endmodule

// ===== rtl/ldw_watchdog.sv
/*
 * loop detect watchdog: config and service registers on the byte bus,
 * tick qualification, stop/halt handling and internal reset request.
 * assumes a synchronous cpu byte bus and tick pulses in clk_sys domain.
 */
// How it works
// - reset loads config 67h: slow oscillator, longest interval
// - config takes one write; a second write resets the chip
// - bits 4:3 pick slow clock, system clock, or stopped
// - bits 2:0 pick 2^11..2^18 slow or 2^13..2^20 system ticks
// - stopped-at-first-write suppresses all software-caused resets
// - key ach clears counter and counting continues
// - any other service value resets the chip
// - bit access to service register resets the chip
// - service register reads 9ah always
// - first config write clears the counter
// - fixed mode always counts slow ticks, ignores bits 4:3
// - fixed mode never stops, even in stop
// - overflow without service resets the chip
// - stoppable mode pauses in halt/stop, keeps count
// - system-clock source holds ~34 us after stop release
// - watchdog reset sets reset-cause bit 4
`timescale 1ns/1ps
`include "ldw_params.svh"
module ldw_watchdog (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic fixed_osc_mode,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_bit_op,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic slow_osc_tick,
    input wire logic sys_clk_tick,
    input wire logic halt_mode,
    input wire logic stop_mode,
    input wire logic osc_settle_done,
    output logic wdt_reset_req,
    output logic [7:0] reset_cause_flag,
    output logic [`LDW_CNT_WIDTH-1:0] dbg_unused_tie
);
    import ldw_pkg::*;

    ldw_cnt_if cnt ();

    logic [7:0] timeout_config_reg;
    logic cfg_written;
    logic wdt_stopped_lock;
    ldw_state_type state;
    logic [15:0] hold_cnt;
    logic stop_seen;
    logic cfg_wr;
    logic svc_wr;
    logic sw_fault;
    logic clk_sel_hi;
    logic clk_sel_lo;
    ldw_src_type src;
    logic src_tick;
    logic paused;

    assign cfg_wr = bus_wr && (bus_addr == `LDW_CFG_ADDR);
    assign svc_wr = bus_wr && (bus_addr == `LDW_SVC_ADDR);
    assign clk_sel_hi = timeout_config_reg[`LDW_CLK_SEL_HI_BIT];
    assign clk_sel_lo = timeout_config_reg[`LDW_CLK_SEL_LO_BIT];

    ////////////////////////////////////////////////////////////////////
    // configuration register, write once
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            timeout_config_reg <= `LDW_CFG_RESET;
            cfg_written <= 1'b0;
            wdt_stopped_lock <= 1'b0;
        end else if (cfg_wr && !cfg_written) begin
            cfg_written <= 1'b1;
            // fixed mode keeps the slow source whatever bits 4:3 say
            if (fixed_osc_mode) begin
                timeout_config_reg <= {`LDW_CFG_FIXED_HI, 2'b00,
                    bus_wdata[2:0]};
            end else begin
                timeout_config_reg <= {`LDW_CFG_FIXED_HI,
                    bus_wdata[4:0]};
                wdt_stopped_lock <= bus_wdata[`LDW_CLK_SEL_HI_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software faults: second config write, bad key, bit access
    assign sw_fault = !wdt_stopped_lock && (
        (cfg_wr && cfg_written) ||
        (svc_wr && bus_bit_op) ||
        (svc_wr && bus_wdata != `LDW_SVC_KEY));

    ////////////////////////////////////////////////////////////////////
    // source select and exponent
    always_comb begin
        if (clk_sel_hi) begin
            src = ldw_src_off;
        end else if (clk_sel_lo) begin
            src = ldw_src_sys;
        end else begin
            src = ldw_src_slow;
        end
    end

    // exponent = base + interval code
    assign cnt.limit_exp = (src == ldw_src_sys) ?
        5'(`LDW_SYS_BASE_EXP + {2'b00, timeout_config_reg[2:0]}) :
        5'(`LDW_SLOW_BASE_EXP + {2'b00, timeout_config_reg[2:0]});

    ////////////////////////////////////////////////////////////////////
    // stop release sequencing: settle wait then fixed hold on fx
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state <= ldw_run;
            hold_cnt <= '0;
            stop_seen <= 1'b0;
        end else begin
            stop_seen <= stop_mode;
            unique case (state)
                ldw_run: begin
                    if (stop_seen && !stop_mode && !fixed_osc_mode &&
                        src == ldw_src_sys) begin
                        state <= ldw_stop_settle;
                    end
                end
                ldw_stop_settle: begin
                    if (osc_settle_done) begin
                        state <= ldw_stop_hold;
                        hold_cnt <= 16'(`LDW_STOP_HOLD_CYC);
                    end
                end
                ldw_stop_hold: begin
                    if (hold_cnt <= 16'h0001) begin
                        state <= ldw_run;
                    end
                    hold_cnt <= hold_cnt - 16'h0001;
                end
            endcase
        end
    end

    // fixed mode never pauses; stoppable mode pauses keeping count
    assign paused = !fixed_osc_mode &&
        (halt_mode || stop_mode || state != ldw_run);

    always_comb begin
        unique case (src)
            ldw_src_slow: src_tick = slow_osc_tick;
            ldw_src_sys: src_tick = sys_clk_tick;
            default: src_tick = 1'b0;
        endcase
    end

    assign cnt.count_en = src_tick && !paused;
    assign cnt.clear = (cfg_wr && !cfg_written) ||
        (svc_wr && !bus_bit_op && bus_wdata == `LDW_SVC_KEY);

    ldw_counter u_counter (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .cnt(cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // internal reset request and reset-cause flag
    // the request is sticky: a one-cycle fault pulse must still be
    // standing when the reset block samples it, so only resetn drops it
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= wdt_reset_req || sw_fault ||
                (cnt.overflow && src != ldw_src_off);
        end
    end

    // the cause flag must survive the reset it requests, so it is
    // set here while the request stands and a resetn with no request standing clears it
    always_ff @(posedge clk_sys) begin
        if (!resetn && !wdt_reset_req) begin
            reset_cause_flag <= 8'h00;
        end else if (wdt_reset_req) begin
            reset_cause_flag[`LDW_RESET_FLAG_BIT] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd && bus_addr == `LDW_CFG_ADDR) begin
            bus_rdata <= timeout_config_reg;
        end else if (bus_rd && bus_addr == `LDW_SVC_ADDR) begin
            bus_rdata <= `LDW_SVC_READ;
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        dbg_unused_tie <= '0;
    end
endmodule

// ===== shared/ldw_cnt_if.sv
/*
 * carrier between the register front and the counter core.
 * assumes one clock, clk_sys, shared by both ends.
 */
`timescale 1ns/1ps
interface ldw_cnt_if;
    import ldw_pkg::*;
    logic count_en;
    logic clear;
    logic [4:0] limit_exp;
    logic overflow;

    modport ctrl (output count_en, output clear, output limit_exp,
        input overflow);
    modport core (input count_en, input clear, input limit_exp,
        output overflow);
endinterface

// ===== shared/ldw_params.svh
/*
 * offsets, field positions, reset values and timing counts of the loop
 * detect watchdog. assumes inclusion by bare name from any design file.
 */
`ifndef LDW_PARAMS_SVH
`define LDW_PARAMS_SVH

`define LDW_CFG_ADDR 16'hff48
`define LDW_SVC_ADDR 16'hff49
`define LDW_CFG_RESET 8'h67
`define LDW_SVC_READ 8'h9a
`define LDW_SVC_KEY 8'hac
`define LDW_CFG_FIXED_HI 3'h3
`define LDW_CLK_SEL_HI_BIT 4
`define LDW_CLK_SEL_LO_BIT 3
`define LDW_INTERVAL_MSB 2
`define LDW_SLOW_BASE_EXP 5'd11
`define LDW_SYS_BASE_EXP 5'd13
`define LDW_CNT_WIDTH 21
`define LDW_RESET_FLAG_BIT 4
`define LDW_CLK_MHZ 40
`define LDW_STOP_HOLD_NS 34000
`define LDW_STOP_HOLD_CYC ((`LDW_STOP_HOLD_NS * `LDW_CLK_MHZ) / 1000)

`endif

// ===== shared/ldw_pkg.sv
/*
 * types of the loop detect watchdog.
 * assumes ldw_params.svh is on the include path.
 */
package ldw_pkg;
    typedef enum logic [1:0] {
        ldw_src_slow,
        ldw_src_sys,
        ldw_src_off
    } ldw_src_type;

    typedef enum {
        ldw_run,
        ldw_stop_settle,
        ldw_stop_hold
    } ldw_state_type;
endpackage

// ===== tb/ldw_chk.sv
/* assertions on the watchdog top ports.
   assumes a bind onto ldw_watchdog and one clock. */
`timescale 1ns/1ps
module ldw_chk (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic fixed_osc_mode,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_bit_op,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic wdt_reset_req
);
    logic wrote;
    logic stopped;
    // decoded accesses
    wire cfg_wr = bus_wr && bus_addr == 16'hff48;
    wire svc_wr = bus_wr && bus_addr == 16'hff49;
    wire cfg_rd = bus_rd && bus_addr == 16'hff48;
    wire svc_rd = bus_rd && bus_addr == 16'hff49;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // mirror of the lock; fixed mode can never stop
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wrote <= 1'b0;
            stopped <= 1'b0;
        end else if (cfg_wr && !wrote) begin
            wrote <= 1'b1;
            stopped <= bus_wdata[4] && !fixed_osc_mode;
        end
    end
    ////////////////////////////////////////
    cfg_read_a: assert property (
        cfg_rd |=> bus_rdata[7:5] == 3'h3) else $error("cfg top bits");
    fixed_src_a: assert property (
        cfg_rd && fixed_osc_mode |=> bus_rdata[4:3] == 2'h0)
        else $error("fixed source bits");
    svc_read_a: assert property (
        svc_rd |=> bus_rdata == 8'h9a) else $error("service read");
    bad_key_a: assert property (
        svc_wr && bus_wdata != 8'hac && !stopped |=> wdt_reset_req)
        else $error("bad key no reset");
    bit_op_a: assert property (
        svc_wr && bus_bit_op && !stopped |=> wdt_reset_req)
        else $error("bit access no reset");
    second_cfg_a: assert property (
        cfg_wr && wrote && !stopped |=> wdt_reset_req)
        else $error("second cfg no reset");
    stop_exempt_a: assert property (
        stopped && !wdt_reset_req |=> !wdt_reset_req)
        else $error("reset while stopped");
    key_ok_a: assert property (
        svc_wr && bus_wdata == 8'hac && !bus_bit_op && !wdt_reset_req
        |=> !wdt_reset_req [*8]) else $error("key caused reset");
    req_hold_a: assert property (
        wdt_reset_req |=> wdt_reset_req) else $error("request dropped");
    // main scenarios reached
    cover property (svc_wr && bus_bit_op);
    cover property (cfg_wr && wrote);
    cover property (stopped && svc_wr);
endmodule
bind ldw_watchdog ldw_chk ldw_chk_inst (.clk_sys, .resetn, .fixed_osc_mode,
    .bus_addr, .bus_wr, .bus_rd, .bus_bit_op, .bus_wdata, .bus_rdata,
    .wdt_reset_req);

// ===== tb/tb_top.sv
/* self-checking bench for the loop detect watchdog.
   assumes the checker bind and ldw_params.svh on the path. */
`timescale 1ns/1ps
`include "ldw_params.svh"
`define CHK(n, e, a) total_checks++; \
    if ((a) !== (e)) begin \
        mismatches++; \
        $display("ERROR %s expected %h seen %h", n, e, a); \
    end
module tb_top;
    logic clk_sys, resetn, fixed_osc_mode, bus_wr, bus_rd, bus_bit_op;
    logic slow_osc_tick, sys_clk_tick, halt_mode, stop_mode;
    logic osc_settle_done;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata;
    wire logic [7:0] bus_rdata, reset_cause_flag;
    wire logic wdt_reset_req;
    wire logic [`LDW_CNT_WIDTH-1:0] dbg_unused_tie;
    int mismatches, total_checks, cycles;
    ldw_watchdog ldw_watchdog_inst (.clk_sys, .resetn, .fixed_osc_mode,
        .bus_addr, .bus_wr, .bus_rd, .bus_bit_op, .bus_wdata, .bus_rdata,
        .slow_osc_tick, .sys_clk_tick, .halt_mode, .stop_mode,
        .osc_settle_done, .wdt_reset_req, .reset_cause_flag,
        .dbg_unused_tie);
    ////////////////////////////////////////
    // 40 MHz clock; a hang ends the run as a mismatch
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            complete_run;
        end
    end
    ////////////////////////////////////////
    task automatic complete_run;
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // inputs move on the falling edge, away from sampling
    // every write is a full byte write unless b makes it a bit operation
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
        input logic b);
        @(negedge clk_sys);
        bus_addr = a;
        bus_wdata = d;
        bus_bit_op = b;
        bus_wr = 1'b1;
        @(negedge clk_sys);
        bus_wr = 1'b0;
        bus_bit_op = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk_sys);
        bus_rd = 1'b0;
        `CHK("bus_rdata", e, bus_rdata)
    endtask
    // waits up to n cycles, leaving early once a request shows
    task automatic req(input int n, input logic e);
        repeat (n) begin
            @(negedge clk_sys);
            if (wdt_reset_req === 1'b1) break;
        end
        `CHK("wdt_reset_req", e, wdt_reset_req)
    endtask
    task automatic rst;
        @(negedge clk_sys);
        resetn = 1'b0;
        @(negedge clk_sys);
        resetn = 1'b1;
    endtask
    ////////////////////////////////////////
    task automatic t_regs;
        rd(16'hff48, 8'h67);
        `CHK("dbg_unused_tie", 21'h0, dbg_unused_tie)
        rd(16'hff49, 8'h9a);
        wr(16'hff49, 8'hac, 1'b0);
        req(8, 1'b0);
        wr(16'hff49, 8'h55, 1'b0);
        req(2, 1'b1);
        rst;
        `CHK("cause_bit4", 1'b1, reset_cause_flag[4])
        wr(16'hff49, 8'hac, 1'b1);
        req(2, 1'b1);
        rst;
    endtask
    // slow code 0 overflows after 2048 ticks from the last clear
    task automatic t_count;
        wr(16'hff48, 8'h60, 1'b0);
        req(1500, 1'b0);
        wr(16'hff49, 8'hac, 1'b0);
        req(2000, 1'b0);
        req(100, 1'b1);
        rst;
    endtask
    // halt pauses the 8192-tick system count without clearing it
    task automatic t_sys;
        wr(16'hff48, 8'h68, 1'b0);
        req(4000, 1'b0);
        halt_mode = 1'b1;
        req(5000, 1'b0);
        halt_mode = 1'b0;
        req(3000, 1'b0);
        req(1400, 1'b1);
        rst;
    endtask
    // stop on the system source: about 1360 held cycles after release
    task automatic t_hold;
        wr(16'hff48, 8'h68, 1'b0);
        req(4000, 1'b0);
        stop_mode = 1'b1;
        req(100, 1'b0);
        stop_mode = 1'b0;
        req(5400, 1'b0);
        req(300, 1'b1);
        rst;
    endtask
    task automatic t_stop;
        wr(16'hff48, 8'h70, 1'b0);
        wr(16'hff48, 8'h60, 1'b0);
        wr(16'hff49, 8'h55, 1'b0);
        wr(16'hff49, 8'hac, 1'b1);
        req(3000, 1'b0);
        rst;
        wr(16'hff48, 8'h60, 1'b0);
        wr(16'hff48, 8'h60, 1'b0);
        req(2, 1'b1);
        rst;
    endtask
    // fixed mode: source bits ignored, stop does not pause
    task automatic t_fixed;
        fixed_osc_mode = 1'b1;
        rst;
        wr(16'hff48, 8'h78, 1'b0);
        rd(16'hff48, 8'h60);
        stop_mode = 1'b1;
        req(1500, 1'b0);
        wr(16'hff49, 8'hac, 1'b0);
        req(2000, 1'b0);
        req(100, 1'b1);
        stop_mode = 1'b0;
        fixed_osc_mode = 1'b0;
        rst;
    endtask
    ////////////////////////////////////////
    initial begin
        {resetn, fixed_osc_mode, bus_wr, bus_rd, bus_bit_op} = 5'h0;
        {halt_mode, stop_mode, bus_addr, bus_wdata} = 26'h0;
        {slow_osc_tick, sys_clk_tick, osc_settle_done} = 3'h7;
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        t_regs;
        t_count;
        t_sys;
        t_hold;
        t_stop;
        t_fixed;
        complete_run;
    end
endmodule
